//--- rtl/mch_pkg.sv
`default_nettype none
package mch_pkg;

	// Command token layout and lengths
	localparam logic [7:0] CMD_LAST_BIT = 8'h2F;
	localparam logic [7:0] CMD_CRC_SPAN = 8'h28;
	localparam logic [7:0] CMD_CRC_LOAD = 8'h27;
	localparam logic [6:0] CMD_CRC_INIT = 7'h00;
	localparam logic CMD_START_VAL = 1'b0;
	localparam logic CMD_DIR_VAL = 1'b1;
	localparam logic TOKEN_END_VAL = 1'b1;

	// Response token lengths and waiting window in card clocks
	localparam logic [7:0] RESP_SHORT_LAST = 8'h2F;
	localparam logic [7:0] RESP_LONG_LAST = 8'h87;
	localparam logic [15:0] RESP_WAIT_LAST = 16'h003F;

	// Checksums
	localparam logic [6:0] CRC7_POLY = 7'h09;
	localparam logic [15:0] CRC16_POLY = 16'h1021;
	localparam logic [15:0] CRC16_INIT = 16'h0000;
	localparam logic [15:0] CRC16_LAST = 16'h000F;
	localparam logic [15:0] CRC16_BITS = 16'h0010;

	// Data block and write status token
	localparam logic [15:0] BLOCK_LAST = 16'h0FFF;
	localparam logic [15:0] STATUS_END = 16'h0004;
	localparam logic [2:0] STATUS_OK = 3'h2;

	// Trailing clocks and card clock divider floor
	localparam logic [15:0] TAIL_LAST = 16'h0007;
	localparam logic [7:0] CLK_DIV_MIN = 8'h02;
	localparam logic [15:0] DATA_WAIT_DEFAULT = 16'hFFFF;

	typedef enum logic [1:0]
	{
		DM_NONE = 2'h0,
		DM_BLOCK = 2'h1,
		DM_STREAM = 2'h2
	} mch_dmode_t;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h0,
		ST_CMD = 4'h1,
		ST_RWAIT = 4'h2,
		ST_RESP = 4'h3,
		ST_DWAIT = 4'h4,
		ST_DRD = 4'h5,
		ST_DCRC = 4'h6,
		ST_WSTART = 4'h7,
		ST_WBITS = 4'h8,
		ST_WCRC = 4'h9,
		ST_WEND = 4'hA,
		ST_WREL = 4'hB,
		ST_WSTAT = 4'hC,
		ST_BUSY = 4'hD,
		ST_TAIL = 4'hE,
		ST_DONE = 4'hF
	} mch_state_t;

	typedef struct packed
	{
		logic [5:0] index;
		logic [31:0] arg;
		logic resp_en;
		logic resp_long;
		logic resp_nocrc;
		mch_dmode_t dmode;
		logic write;
		logic multi;
	} mch_cmd_t;

	typedef struct packed
	{
		logic [135:0] token;
		logic timeout;
		logic crc_err;
		logic data_err;
	} mch_resp_t;

	function automatic logic [6:0] crc7_step(input logic [6:0] c, input logic b);
		logic fb;
		fb = c[6] ^ b;
		crc7_step = {c[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
	endfunction

	function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[15] ^ b;
		crc16_step = {c[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
	endfunction

endpackage
`default_nettype wire

//--- rtl/mch_hs_cross.sv
`default_nettype none
module mch_hs_cross #(
	parameter int WIDTH = 8
) (
	input wire logic src_clk_i,
	input wire logic dst_clk_i,
	input wire logic rst_b_i,
	input wire logic src_valid_i,
	input wire logic [WIDTH-1:0] src_data_i,
	output logic src_ready_o,
	output logic dst_valid_o,
	output logic [WIDTH-1:0] dst_data_o,
	input wire logic dst_ready_i
);
	logic req;
	logic ack;
	logic [1:0] req_sync;
	logic [1:0] ack_sync;
	logic [WIDTH-1:0] hold;

	// Source side: word held stable until the toggle comes back
	always_ff @(posedge src_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			req <= 1'b0;
			ack_sync <= 2'b00;
			hold <= '0;
		end
		else
		begin
			ack_sync <= {ack_sync[0], ack};
			if (src_valid_i && src_ready_o)
			begin
				req <= ~req;
				hold <= src_data_i;
			end
		end
	end

	// Destination side
	always_ff @(posedge dst_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ack <= 1'b0;
			req_sync <= 2'b00;
		end
		else
		begin
			req_sync <= {req_sync[0], req};
			if (dst_valid_o && dst_ready_i)
				ack <= ~ack;
		end
	end

	assign src_ready_o = (req == ack_sync[1]);
	assign dst_valid_o = (req_sync[1] != ack);
	assign dst_data_o = hold;
endmodule
`default_nettype wire

//--- rtl/mch_host.sv
// Summary of operation
// [R1] One bit per card clock on each line
// [R2] Card clock rate adjustable, stoppable
// [R3] Command line open-drain in init, else push-pull
// [R4] Data line push-pull, single driver at once
// [R5] Commands out, responses back on command line
// [R6] Host alone starts every transfer
// [R7] Message-based card initialization before other transfers
// [R8] Data tokens serial on data line, both directions
// [R9] Command then response, optional data token
// [R10] Launch and sample on host card clock
// [R11] Host assigns and uses 16-bit card address
// [R12] Stream transfer runs until stop command
// [R13] Blocks carry CRC; multi-block ends by stop
// [R14] Wait for card busy release after writes; here only block writes wait, stream writes go straight to ST_TAIL
// [R15] Command tokens exactly 48 bits
// [R16] Start bit low at 47, end high at 0
// [R17] Direction bit 46 driven high
// [R18] 7-bit checksum in bits 7 to 1
// [R19] Index in 45:40, argument in 39:8
// [R20] Card registers reached only through commands
// [R21] Responses 48 or 136 bits, framed
// [R22] Block data CRC16 CCITT, stream unprotected
// [R23] Eight card clocks before stopping clock
// [R24] CRC7 polynomial x^7+x^3+1, MSB first
`default_nettype none
module mch_host #(
	parameter logic [15:0] DATA_WAIT_CLOCKS = mch_pkg::DATA_WAIT_DEFAULT
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic link_clk_i,
	input wire logic cmd_valid_i,
	input wire mch_pkg::mch_cmd_t cmd_i,
	output logic cmd_ready_o,
	output logic resp_valid_o,
	output mch_pkg::mch_resp_t resp_o,
	input wire logic resp_ready_i,
	input wire logic wr_valid_i,
	input wire logic [7:0] wr_data_i,
	output logic wr_ready_o,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	input wire logic rd_ready_i,
	input wire logic stop_i,
	input wire logic open_drain_i,
	input wire logic [7:0] clk_div_i,
	output logic card_clk_o,
	input wire logic card_command_line_i,
	output logic card_command_line_o,
	output logic card_command_line_oe_o,
	input wire logic card_data_line_i,
	output logic card_data_line_o,
	output logic card_data_line_oe_o
);
	import mch_pkg::*;

	localparam logic [15:0] DATA_WAIT_LAST = DATA_WAIT_CLOCKS - 16'h0001;

	mch_state_t state;
	mch_state_t state_q;
	mch_cmd_t cq;
	mch_cmd_t cmd_l;
	mch_resp_t resp_w;
	logic [11:0] sync1;
	logic [11:0] sync2;
	logic [7:0] ccnt;
	logic card_clk;
	logic [7:0] cnt;
	logic [15:0] wcnt;
	logic [15:0] dcnt;
	logic [47:0] sh;
	logic [6:0] crc7;
	logic [15:0] crc16;
	logic [135:0] rsh;
	logic [7:0] rbyte;
	logic [7:0] wsh;
	logic [2:0] stat;
	logic rx_pend;
	logic timeout;
	logic crc_err;
	logic data_err;
	logic cmd_bit;
	logic cmd_drv;
	logic dat_bit;
	logic dat_drv;
	logic cmd_l_valid;
	logic tx_valid;
	logic [7:0] tx_data;
	logic rx_src_ready;
	logic resp_src_ready;

	wire logic cin;
	wire logic din;
	wire logic od;
	wire logic stop_s;
	wire logic [7:0] div_s;
	wire logic [7:0] div_eff;
	wire logic at_edge;
	wire logic stall;
	wire logic run;
	wire logic tick_rise;
	wire logic tick_fall;
	wire logic byte_first;
	wire logic byte_last;
	wire logic is_block;
	wire logic w_bit;
	wire logic tx_ready;
	wire logic [7:0] resp_last;
	wire logic resp_bad;
	wire mch_state_t after_resp;
	wire mch_state_t next_block;

	// Pins and quasi-static controls enter the link domain via two flops
	always_ff @(posedge link_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sync1 <= 12'h003;
			sync2 <= 12'h003;
		end
		else
		begin
			sync1 <= {clk_div_i, stop_i, open_drain_i, card_data_line_i, card_command_line_i};
			sync2 <= sync1;
		end
	end

	assign cin = sync2[0];
	assign din = sync2[1];
	assign od = sync2[2];
	assign stop_s = sync2[3];
	assign div_s = sync2[11:4];

	// Card clock: divided link clock, parked low when not running
	assign div_eff = (div_s < CLK_DIV_MIN) ? CLK_DIV_MIN : div_s;
	assign at_edge = (ccnt >= div_eff);
	assign stall = rx_pend || ((state == ST_WBITS) && byte_first && !tx_valid); // [R2]
	assign run = (state != ST_IDLE) && (state != ST_DONE) && !stall; // [R2] [R23]
	assign tick_rise = at_edge && !card_clk && run;
	assign tick_fall = at_edge && card_clk;

	always_ff @(posedge link_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			card_clk <= 1'b0;
			ccnt <= 8'h00;
		end
		else if (tick_rise || tick_fall)
		begin
			card_clk <= ~card_clk; // [R1] [R10]
			ccnt <= 8'h00;
		end
		else if (!at_edge)
			ccnt <= ccnt + 8'h01;
	end

	// Card clocks spent in the current state
	always_ff @(posedge link_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= ST_IDLE;
			wcnt <= 16'h0000;
		end
		else
		begin
			state_q <= state;
			if (state != state_q)
				wcnt <= 16'h0000;
			else if (tick_rise)
				wcnt <= wcnt + 16'h0001;
		end
	end

	assign byte_first = (dcnt[2:0] == 3'h0);
	assign byte_last = (dcnt[2:0] == 3'h7);
	assign is_block = (cq.dmode == DM_BLOCK);
	assign w_bit = byte_first ? tx_data[7] : wsh[7];
	assign tx_ready = (state == ST_WBITS) && tick_fall && byte_first;
	assign resp_last = cq.resp_long ? RESP_LONG_LAST : RESP_SHORT_LAST; // [R21]
	assign resp_bad = !cin || (!cq.resp_long && !cq.resp_nocrc && (rsh[6:0] != crc7)); // [R21]
	assign after_resp = (cq.dmode == DM_NONE) ? ST_TAIL : (cq.write ? ST_WSTART : ST_DWAIT); // [R9]
	assign next_block = (cq.multi && !stop_s) ? (cq.write ? ST_WSTART : ST_DWAIT) : ST_TAIL; // [R13]
	assign resp_w = '{token: rsh, timeout: timeout, crc_err: crc_err, data_err: data_err};

	// Protocol engine: launches on card clock fall, samples on rise
	always_ff @(posedge link_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state <= ST_IDLE;
			cq <= '0;
			cnt <= 8'h00;
			dcnt <= 16'h0000;
			sh <= 48'h000000000000;
			crc7 <= CMD_CRC_INIT;
			crc16 <= CRC16_INIT;
			rsh <= '0;
			rbyte <= 8'h00;
			wsh <= 8'h00;
			stat <= 3'h0;
			rx_pend <= 1'b0;
			timeout <= 1'b0;
			crc_err <= 1'b0;
			data_err <= 1'b0;
			cmd_bit <= 1'b1;
			cmd_drv <= 1'b0;
			dat_bit <= 1'b1;
			dat_drv <= 1'b0;
		end
		else
		begin
			if (rx_pend && rx_src_ready)
				rx_pend <= 1'b0;
			unique case (state)
			ST_IDLE:
				if (cmd_l_valid) // [R6] [R7] [R11] [R20]
				begin
					cq <= cmd_l;
					sh <= {CMD_START_VAL, CMD_DIR_VAL, cmd_l.index, cmd_l.arg, 7'h00, TOKEN_END_VAL}; // [R15] [R16] [R17] [R19]
					cnt <= 8'h00;
					crc7 <= CMD_CRC_INIT;
					timeout <= 1'b0;
					crc_err <= 1'b0;
					data_err <= 1'b0;
					state <= ST_CMD;
				end
			ST_CMD:
				if (tick_fall)
				begin
					if (cnt > CMD_LAST_BIT)
					begin
						cmd_drv <= 1'b0;
						state <= cq.resp_en ? ST_RWAIT : after_resp; // [R5]
					end
					else
					begin
						cmd_drv <= 1'b1; // [R3]
						cmd_bit <= sh[47];
						sh <= {sh[46:0], 1'b0};
						cnt <= cnt + 8'h01;
						if (cnt < CMD_CRC_SPAN)
							crc7 <= crc7_step(crc7, sh[47]); // [R24]
						if (cnt == CMD_CRC_LOAD)
							sh[47:40] <= {crc7_step(crc7, sh[47]), TOKEN_END_VAL}; // [R18]
					end
				end
			ST_RWAIT:
				if (tick_rise)
				begin
					if (!cin)
					begin
						rsh <= {rsh[134:0], 1'b0};
						cnt <= 8'h01;
						crc7 <= crc7_step(CMD_CRC_INIT, 1'b0);
						state <= ST_RESP; // [R5]
					end
					else if (wcnt >= RESP_WAIT_LAST)
					begin
						timeout <= 1'b1;
						state <= ST_TAIL;
					end
				end
			ST_RESP:
				if (tick_rise)
				begin
					rsh <= {rsh[134:0], cin};
					cnt <= cnt + 8'h01;
					if (cnt < CMD_CRC_SPAN)
						crc7 <= crc7_step(crc7, cin);
					if (cnt == resp_last)
					begin
						crc_err <= resp_bad; // [R21]
						state <= after_resp;
					end
				end
			ST_DWAIT:
				if (tick_rise)
				begin
					if (!din)
					begin
						dcnt <= 16'h0000;
						crc16 <= CRC16_INIT;
						state <= ST_DRD; // [R8]
					end
					else if (wcnt >= DATA_WAIT_LAST)
					begin
						timeout <= 1'b1;
						state <= ST_TAIL;
					end
				end
			ST_DRD:
				if (tick_rise)
				begin
					rbyte <= {rbyte[6:0], din}; // [R8]
					dcnt <= dcnt + 16'h0001;
					crc16 <= crc16_step(crc16, din);
					if (byte_last)
						rx_pend <= 1'b1;
					if (is_block && (dcnt == BLOCK_LAST))
					begin
						dcnt <= 16'h0000;
						state <= ST_DCRC; // [R13]
					end
					else if (!is_block && byte_last && stop_s)
						state <= ST_TAIL; // [R12]
				end
			ST_DCRC:
				if (tick_rise)
				begin
					dcnt <= dcnt + 16'h0001;
					if (dcnt < CRC16_BITS)
						crc16 <= crc16_step(crc16, din); // [R22]
					else
					begin
						data_err <= data_err || (crc16 != CRC16_INIT) || !din; // [R22]
						state <= next_block; // [R13]
					end
				end
			ST_WSTART:
				if (tick_fall)
				begin
					dat_drv <= 1'b1; // [R4]
					dat_bit <= 1'b0;
					dcnt <= 16'h0000;
					crc16 <= CRC16_INIT;
					state <= ST_WBITS;
				end
			ST_WBITS:
				if (tick_fall)
				begin
					dat_bit <= w_bit; // [R8]
					wsh <= byte_first ? {tx_data[6:0], 1'b0} : {wsh[6:0], 1'b0};
					crc16 <= crc16_step(crc16, w_bit);
					dcnt <= dcnt + 16'h0001;
					if (is_block && (dcnt == BLOCK_LAST))
					begin
						dcnt <= 16'h0000;
						state <= ST_WCRC; // [R13]
					end
					else if (!is_block && byte_last && stop_s)
						state <= ST_WEND; // [R12]
				end
			ST_WCRC:
				if (tick_fall)
				begin
					dat_bit <= crc16[15]; // [R22]
					crc16 <= {crc16[14:0], 1'b0};
					dcnt <= dcnt + 16'h0001;
					if (dcnt == CRC16_LAST)
						state <= ST_WEND;
				end
			ST_WEND:
				if (tick_fall)
				begin
					dat_bit <= TOKEN_END_VAL;
					state <= ST_WREL;
				end
			ST_WREL:
				if (tick_fall)
				begin
					dat_drv <= 1'b0; // [R4]
					dcnt <= 16'h0000;
					state <= is_block ? ST_WSTAT : ST_TAIL;
				end
			ST_WSTAT:
				if (tick_rise)
				begin
					if (dcnt == 16'h0000)
					begin
						if (!din)
							dcnt <= 16'h0001;
						else if (wcnt >= RESP_WAIT_LAST)
						begin
							timeout <= 1'b1;
							state <= ST_TAIL;
						end
					end
					else if (dcnt < STATUS_END)
					begin
						stat <= {stat[1:0], din};
						dcnt <= dcnt + 16'h0001;
					end
					else
					begin
						data_err <= data_err || (stat != STATUS_OK) || !din;
						state <= ST_BUSY;
					end
				end
			ST_BUSY:
				if (tick_rise && din)
					state <= next_block; // [R14]
			// Leave on the fall after the eighth rise, so the clock is parked before the result
			ST_TAIL:
				if (tick_fall && (wcnt > TAIL_LAST))
					state <= ST_DONE; // [R23]
			ST_DONE:
				if (resp_src_ready)
					state <= ST_IDLE;
			endcase
		end
	end

	// Open-drain mode only ever pulls the command line low
	assign card_command_line_o = od ? 1'b0 : cmd_bit; // [R3]
	assign card_command_line_oe_o = cmd_drv && (!od || !cmd_bit); // [R3]
	assign card_data_line_o = dat_bit;
	assign card_data_line_oe_o = dat_drv; // [R4]
	assign card_clk_o = card_clk;

	// Domain crossings between the user side and the link side
	mch_hs_cross #(.WIDTH($bits(mch_cmd_t))) u_cmd (
		.src_clk_i(clk_i),
		.dst_clk_i(link_clk_i),
		.rst_b_i(rst_b_i),
		.src_valid_i(cmd_valid_i),
		.src_data_i(cmd_i),
		.src_ready_o(cmd_ready_o),
		.dst_valid_o(cmd_l_valid),
		.dst_data_o(cmd_l),
		.dst_ready_i(state == ST_IDLE)
	);

	mch_hs_cross #(.WIDTH($bits(mch_resp_t))) u_resp (
		.src_clk_i(link_clk_i),
		.dst_clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.src_valid_i(state == ST_DONE),
		.src_data_i(resp_w),
		.src_ready_o(resp_src_ready),
		.dst_valid_o(resp_valid_o),
		.dst_data_o(resp_o),
		.dst_ready_i(resp_ready_i)
	);

	mch_hs_cross #(.WIDTH(8)) u_wr (
		.src_clk_i(clk_i),
		.dst_clk_i(link_clk_i),
		.rst_b_i(rst_b_i),
		.src_valid_i(wr_valid_i),
		.src_data_i(wr_data_i),
		.src_ready_o(wr_ready_o),
		.dst_valid_o(tx_valid),
		.dst_data_o(tx_data),
		.dst_ready_i(tx_ready)
	);

	mch_hs_cross #(.WIDTH(8)) u_rd (
		.src_clk_i(link_clk_i),
		.dst_clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.src_valid_i(rx_pend),
		.src_data_i(rbyte),
		.src_ready_o(rx_src_ready),
		.dst_valid_o(rd_valid_o),
		.dst_data_o(rd_data_o),
		.dst_ready_i(rd_ready_i)
	);
endmodule
`default_nettype wire

//--- testbench/mch_host_chk.sv
`default_nettype none
module mch_host_chk (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic link_clk_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire logic resp_valid_o,
	input wire mch_pkg::mch_resp_t resp_o,
	input wire logic resp_ready_i,
	input wire logic open_drain_i,
	input wire logic card_clk_o,
	input wire logic card_command_line_o,
	input wire logic card_command_line_oe_o,
	input wire logic card_data_line_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import mch_pkg::*;
	logic [1:0] pend;
	logic cmd_take;
	logic resp_take;
	logic clk_q;
	logic clk_rise;
	logic pp_rise;
	logic [7:0] bit_cnt;
	assign clk_rise = card_clk_o & ~clk_q;
	assign pp_rise = clk_rise & card_command_line_oe_o & ~open_drain_i;
	assign cmd_take = cmd_valid_i & cmd_ready_o;
	assign resp_take = resp_valid_o & resp_ready_i;
	// Commands accepted whose result the user has not yet taken
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			pend <= 2'h0;
		else
			pend <= pend + {1'b0, cmd_take} - {1'b0, resp_take};
	end
	// Counts card clock rises while the host drives the command line
	always_ff @(posedge link_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			clk_q <= 1'b0;
			bit_cnt <= 8'h00;
		end
		else
		begin
			clk_q <= card_clk_o;
			bit_cnt <= card_command_line_oe_o ? bit_cnt + {7'h00, clk_rise} : 8'h00;
		end
	end
	a_od_drive_low: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		open_drain_i && card_command_line_oe_o |-> !card_command_line_o) else $error("od high");
	a_idle_bus_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		pend == 2'h0 |-> !card_clk_o && !card_command_line_oe_o) else $error("idle busy");
	a_idle_data_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		pend == 2'h0 |-> !card_data_line_oe_o) else $error("idle data drive");
	a_launch_clk_low: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		card_command_line_oe_o && $changed(card_command_line_o) |-> !card_clk_o)
		else $error("launch on high clock");
	a_start_bit_low: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		pp_rise && bit_cnt == 8'h00 |-> !card_command_line_o) else $error("start bit");
	a_dir_bit_high: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		pp_rise && bit_cnt == 8'h01 |-> card_command_line_o) else $error("direction bit");
	a_end_bit_high: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		pp_rise && bit_cnt == 8'h2F |-> card_command_line_o) else $error("end bit");
	a_cmd_len_48: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		$fell(card_command_line_oe_o) && !open_drain_i |-> bit_cnt == 8'h30)
		else $error("command length");
	a_resp_held: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		resp_valid_o && !resp_ready_i |=> resp_valid_o && $stable(resp_o))
		else $error("result dropped");
	c_pp_cmd: cover property (@(posedge link_clk_i) $fell(card_command_line_oe_o) && !open_drain_i);
	c_od_cmd: cover property (@(posedge link_clk_i) open_drain_i && card_command_line_oe_o);
	c_timeout: cover property (@(posedge clk_i) resp_valid_o && resp_o.timeout);
endmodule
bind mch_host mch_host_chk i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk_i),
	.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
	.resp_ready_i(resp_ready_i), .open_drain_i(open_drain_i), .card_clk_o(card_clk_o),
	.card_command_line_o(card_command_line_o), .card_command_line_oe_o(card_command_line_oe_o),
	.card_data_line_oe_o(card_data_line_oe_o));
`default_nettype wire

//--- testbench/mch_card_model.sv
`default_nettype none
module mch_card_model (
	input wire logic card_clk_i,
	input wire logic cmd_line_i,
	input wire logic answer_i,
	input wire logic data_i,
	input wire logic [7:0] byte_i,
	output logic cmd_drv_o,
	output logic dat_drv_o,
	output logic [47:0] cap_o,
	output logic [47:0] rsp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Checksum x^7+x^3+1, first bit in first
	function automatic logic [6:0] crc7(input logic [39:0] d);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 39; i >= 0; i--)
			c = {c[5:0], 1'b0} ^ ((c[6] ^ d[i]) ? 7'h09 : 7'h00);
		return c;
	endfunction
	initial
	begin
		cmd_drv_o = 1'b1;
		dat_drv_o = 1'b1;
		cap_o = '0;
		rsp_o = '0;
		forever
		begin
			@(posedge card_clk_i);
			// Samples the command on rises, answers only when answer_i is set
			if (cmd_line_i === 1'b0)
			begin
				cap_o[47] = 1'b0;
				for (int i = 46; i >= 0; i--)
				begin
					@(posedge card_clk_i);
					cap_o[i] = cmd_line_i;
				end
				if (answer_i)
				begin
					rsp_o = {2'b00, cap_o[45:40], 32'hC3A5_0F96, 8'h01};
					rsp_o[7:1] = crc7(rsp_o[47:8]);
					repeat (2) @(negedge card_clk_i);
					for (int i = 47; i >= 0; i--)
					begin
						@(negedge card_clk_i);
						#1 cmd_drv_o = rsp_o[i];
					end
					@(negedge card_clk_i);
					#1 cmd_drv_o = 1'b1;
					// Stream data: start bit, one byte MSB first, then release
					if (data_i)
					begin
						@(negedge card_clk_i);
						#1 dat_drv_o = 1'b0;
						for (int i = 7; i >= 0; i--)
						begin
							@(negedge card_clk_i);
							#1 dat_drv_o = byte_i[i];
						end
						@(negedge card_clk_i);
						#1 dat_drv_o = 1'b1;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- testbench/mch_host_tb_top.sv
`default_nettype none
module mch_host_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import mch_pkg::*;
	localparam logic [7:0] STREAM_BYTE = 8'hA7;
	logic data_en = 1'b0;
	logic card_dat;
	int rd_seen = 0;
	logic clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic cmd_valid_i = 1'b0;
	logic resp_ready_i = 1'b0;
	logic open_drain_i = 1'b0;
	logic answer = 1'b1;
	logic [7:0] clk_div_i = 8'h02;
	logic wr_valid_i = 1'b0;
	logic [7:0] wr_data_i = 8'h00;
	logic rd_ready_i = 1'b1;
	logic stop_i = 1'b0;
	mch_cmd_t cmd_i = '0;
	mch_resp_t resp;
	mch_resp_t resp_o;
	logic cmd_ready_o, resp_valid_o, wr_ready_o, rd_valid_o, card_clk_o, card_drv;
	logic cmd_o, cmd_oe, dat_o, dat_oe, cmd_line, dat_line;
	logic [7:0] rd_data_o;
	logic [47:0] cap, rsp;
	int miscompares = 0;
	int samples_checked = 0;
	// Pull-ups on both lines
	assign cmd_line = (cmd_oe ? cmd_o : 1'b1) & card_drv;
	assign dat_line = (dat_oe ? dat_o : 1'b1) & card_dat;
	always @(posedge clk_i)
		if (rd_valid_o && rd_ready_i)
			rd_seen++;
	always #2.5 clk_i = ~clk_i;
	initial
	begin
		#7;
		forever #16 link_clk_i = ~link_clk_i;
	end
	mch_host #(.DATA_WAIT_CLOCKS(16'h0040)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.link_clk_i(link_clk_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
		.cmd_ready_o(cmd_ready_o), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
		.resp_ready_i(resp_ready_i), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
		.wr_ready_o(wr_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
		.rd_ready_i(rd_ready_i), .stop_i(stop_i), .open_drain_i(open_drain_i),
		.clk_div_i(clk_div_i), .card_clk_o(card_clk_o), .card_command_line_i(cmd_line),
		.card_command_line_o(cmd_o), .card_command_line_oe_o(cmd_oe),
		.card_data_line_i(dat_line), .card_data_line_o(dat_o), .card_data_line_oe_o(dat_oe));
	mch_card_model i_card (.card_clk_i(card_clk_o), .cmd_line_i(cmd_line), .answer_i(answer),
		.data_i(data_en), .byte_i(STREAM_BYTE), .cmd_drv_o(card_drv), .dat_drv_o(card_dat),
		.cap_o(cap), .rsp_o(rsp));
	task automatic check_bit(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic check_tok(input string name, input logic [47:0] exp, input logic [47:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Issues one command, collects its result and checks the token the card saw
	task automatic run_cmd(input logic [5:0] idx, input logic [31:0] arg, input logic ren,
		input mch_dmode_t dm);
		int n;
		logic [47:0] exp;
		exp = {2'b01, idx, arg, 8'h01};
		exp[7:1] = i_card.crc7(exp[47:8]);
		@(posedge clk_i);
		#1 cmd_i = '0;
		cmd_i.index = idx;
		cmd_i.arg = arg;
		cmd_i.resp_en = ren;
		cmd_i.dmode = dm;
		cmd_valid_i = 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end while (cmd_ready_o !== 1'b1 && n < 1000);
		#1 cmd_valid_i = 1'b0;
		n = 0;
		while (resp_valid_o !== 1'b1 && n < 40000)
		begin
			@(posedge clk_i);
			n++;
		end
		check_bit("result valid", 1'b1, resp_valid_o);
		resp = resp_o;
		#1 resp_ready_i = 1'b1;
		@(posedge clk_i);
		#1 resp_ready_i = 1'b0;
		check_tok("command token", exp, cap);
	endtask
	task automatic t_answered;
		logic [5:0] idx [2] = '{6'h3F, 6'h00};
		logic [31:0] arg [2] = '{32'hFFFF_FFFF, 32'h0000_0000};
		logic [7:0] div [2] = '{8'h02, 8'h05};
		open_drain_i = 1'b0;
		answer = 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			clk_div_i = div[i];
			run_cmd(idx[i], arg[i], 1'b1, DM_NONE);
			check_tok("response", rsp, resp.token[47:0]);
			check_bit("timeout", 1'b0, resp.timeout);
			check_bit("crc error", 1'b0, resp.crc_err);
		end
	endtask
	task automatic t_open_drain;
		open_drain_i = 1'b1;
		answer = 1'b0;
		clk_div_i = 8'h02;
		run_cmd(6'h01, 32'h80FF_8000, 1'b0, DM_NONE);
		check_bit("no-answer timeout", 1'b0, resp.timeout);
		open_drain_i = 1'b0;
	endtask
	task automatic t_stream_read;
		answer = 1'b1;
		data_en = 1'b1;
		stop_i = 1'b1;
		run_cmd(6'h14, 32'h0000_0200, 1'b1, DM_STREAM);
		check_tok("stream response", rsp, resp.token[47:0]);
		check_bit("stream timeout", 1'b0, resp.timeout);
		check_tok("read byte", {40'h0, STREAM_BYTE}, {40'h0, rd_data_o});
		check_tok("bytes read", 48'h1, {16'h0, rd_seen});
		stop_i = 1'b0;
		data_en = 1'b0;
	endtask
	task automatic t_silent;
		answer = 1'b0;
		run_cmd(6'h07, 32'h1234_0000, 1'b1, DM_NONE);
		check_bit("silent timeout", 1'b1, resp.timeout);
	endtask
	task automatic tally_and_finish;
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#400000;
		miscompares++;
		tally_and_finish();
	end
	initial
	begin
		repeat (16) @(posedge clk_i);
		#1 rst_b_i = 1'b1;
		t_open_drain();
		t_answered();
		t_stream_read();
		t_silent();
		tally_and_finish();
	end
endmodule
`default_nettype wire
